// file: logic/wdt_pkg.sv
/*
 * wdt_pkg: constants and carrier types for the watchdog timeout/reset block.
 * assumes a single 50 MHz system clock and an active-low async chip reset.
 */
package wdt_pkg;
    localparam int WDT_CNT_W = 24;
    localparam int WDT_RST_W = 10;
    localparam logic [WDT_RST_W-1:0] WDT_RST_CYCLES = 10'h200;
    localparam logic [1:0] WDT_SEL_RESET = 2'h0;
    localparam int WDT_TO_EXP_BASE = 15;
    localparam int WDT_TO_EXP_STEP = 3;

    // software-side control bundle, sampled each clock
    typedef struct packed {
        logic restart;
        logic run;
        logic int_enable;
        logic flag_clear;
        logic [1:0] timeout_select;
    } wdt_ctrl_t;

    // status bundle returned to the processor and reset logic
    typedef struct packed {
        logic timeout_flag;
        logic irq;
        logic sys_reset;
        logic reset_stage;
    } wdt_stat_t;

    typedef enum logic [1:0] {
        WDT_ST_COUNT,
        WDT_ST_RSTAGE,
        WDT_ST_FIRE
    } wdt_state_t;
endpackage : wdt_pkg

// file: logic/wdt_tap.sv
/*
 * wdt_tap: decodes the timeout select into a terminal-count test.
 * assumes the count is the watchdog counter value, gated by run in the counting stage.
 */
`timescale 1ns/1ns
module wdt_tap
    import wdt_pkg::*;
(
    input wire logic [WDT_CNT_W-1:0] count_in,
    input wire logic [1:0] timeout_select_in,
    output logic terminal_out
);
    // terminal when all bits below the selected exponent are ones
    always_comb
    begin
        unique case (timeout_select_in)
            2'h0: terminal_out = &count_in[WDT_TO_EXP_BASE-1:0];
            2'h1: terminal_out =
                &count_in[WDT_TO_EXP_BASE+WDT_TO_EXP_STEP-1:0];
            2'h2: terminal_out =
                &count_in[WDT_TO_EXP_BASE+2*WDT_TO_EXP_STEP-1:0];
            2'h3: terminal_out = &count_in;
        endcase
    end
endmodule : wdt_tap

// file: logic/wdt_core.sv
/*
 * wdt_core: watchdog with interrupt timeout stage and reset stage.
 * assumes software controls arrive as synchronous levels/pulses on the
 * system clock; sys_reset_out is fed to the chip reset generator.
 */
`timescale 1ns/1ns
module wdt_core
    import wdt_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire wdt_ctrl_t ctrl_in,
    output wdt_stat_t stat_out
);
    // stage machine and its reset-stage down counter
    wdt_state_t state_reg, state_next;
    logic [WDT_RST_W-1:0] rcnt_reg, rcnt_next;
    // watchdog count, gated by run in the counting stage
    logic [WDT_CNT_W-1:0] cnt_reg, cnt_next;
    // sticky interrupt timeout flag
    logic flag_reg, flag_next;
    // status outputs, each held in a flop of its own
    logic irq_reg, irq_next;
    logic srst_reg, srst_next;
    logic stage_reg, stage_next;
    // decoded events shared by the state groups below
    logic terminal;
    logic count_stage;
    logic reset_stage;
    logic fire_stage;
    logic timeout_hit;
    logic stage_expire;
    logic restart_take;

    // terminal-count test for the selected timeout
    wdt_tap u_tap (
        .count_in(cnt_reg),
        .timeout_select_in(ctrl_in.timeout_select),
        .terminal_out(terminal)
    );

    // stage decode from the state flop
    assign count_stage = (state_reg == WDT_ST_COUNT);
    assign reset_stage = (state_reg == WDT_ST_RSTAGE);
    assign fire_stage = (state_reg == WDT_ST_FIRE);

    // a timeout only counts while software lets the count run
    assign timeout_hit = count_stage & ctrl_in.run & terminal;
    // the reset stage ends once its down counter reads zero
    assign stage_expire = reset_stage & (rcnt_reg == '0);
    // restart is refused once the reset is committed: in the
    // expiry cycle and in the reset pulse cycle; a late restart
    // there could otherwise leave a half-issued reset behind
    assign restart_take = ctrl_in.restart & ~fire_stage
        & ~stage_expire;

    // next state of the stage machine and the reset-stage counter
    always_comb
    begin
        state_next = state_reg;
        rcnt_next = rcnt_reg;
        unique case (state_reg)
            WDT_ST_COUNT:
            begin
                if (timeout_hit)
                begin
                    // loaded one short: the zero cycle is the last one
                    rcnt_next = WDT_RST_CYCLES - 1'b1;
                    state_next = WDT_ST_RSTAGE;
                end
            end
            WDT_ST_RSTAGE:
            begin
                rcnt_next = rcnt_reg - 1'b1;
                if (stage_expire)
                begin
                    state_next = WDT_ST_FIRE;
                end
            end
            WDT_ST_FIRE:
            begin
                // the watchdog's own reset sends it back to counting
                rcnt_next = '0;
                state_next = WDT_ST_COUNT;
            end
            default:
            begin
                // unused code: recover into the counting stage
                rcnt_next = '0;
                state_next = WDT_ST_COUNT;
            end
        endcase
        // restart wins in any stage up to, but not in, the reset-stage expiry cycle
        if (restart_take)
        begin
            rcnt_next = '0;
            state_next = WDT_ST_COUNT;
        end
    end

    // stage registers
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_reg <= WDT_ST_COUNT;
            rcnt_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            rcnt_reg <= rcnt_next;
        end
    end

    // next value of the watchdog count
    always_comb
    begin
        cnt_next = cnt_reg;
        unique case (state_reg)
            WDT_ST_COUNT:
            begin
                if (timeout_hit)
                begin
                    // the next interval starts from zero
                    cnt_next = '0;
                end
                else if (ctrl_in.run)
                begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            WDT_ST_RSTAGE:
            begin
                // run is ignored here so software cannot stall the reset
                cnt_next = cnt_reg + 1'b1;
            end
            WDT_ST_FIRE:
            begin
                cnt_next = '0;
            end
            default:
            begin
                cnt_next = '0;
            end
        endcase
        if (restart_take)
        begin
            cnt_next = '0;
        end
    end

    // count register
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cnt_reg <= '0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    // next value of the sticky timeout flag
    always_comb
    begin
        flag_next = flag_reg;
        if (ctrl_in.flag_clear)
        begin
            flag_next = 1'b0;
        end
        if (fire_stage)
        begin
            flag_next = 1'b0;
        end
        // set beats a same-cycle clear, so no timeout is ever lost
        if (timeout_hit)
        begin
            flag_next = 1'b1;
        end
    end

    // flag register
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            flag_reg <= 1'b0;
        end
        else
        begin
            flag_reg <= flag_next;
        end
    end

    // next values of the registered status outputs
    always_comb
    begin
        irq_next = flag_next & ctrl_in.int_enable;
        srst_next = stage_expire;
        // stage bit tracks the next state so it has no gap or lag
        stage_next = (state_next == WDT_ST_RSTAGE);
    end

    // status registers; irq, sys_reset and reset_stage come straight from these flops
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            irq_reg <= 1'b0;
            srst_reg <= 1'b0;
            stage_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= irq_next;
            srst_reg <= srst_next;
            stage_reg <= stage_next;
        end
    end

    // status bundle, one flop per field
    assign stat_out.timeout_flag = flag_reg;
    assign stat_out.irq = irq_reg;
    assign stat_out.sys_reset = srst_reg;
    assign stat_out.reset_stage = stage_reg;
endmodule : wdt_core

// file: tb/wdt_asserts.sv
/* wdt_asserts: status timing checks; assumes one clock, async reset */
`timescale 1ns/1ns
module wdt_chk
    import wdt_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire wdt_ctrl_t ctrl_in,
    input wire wdt_stat_t stat_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    // stage entry and fire seen as rising edges of the status bits
    sequence s_enter; $rose(stat_out.reset_stage); endsequence
    sequence s_fire; $rose(stat_out.sys_reset); endsequence
    // cycles the reset stage has stood; saturates rather than wraps
    logic [WDT_RST_W:0] stage_len;
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            stage_len <= '0;
        else if (!stat_out.reset_stage)
            stage_len <= '0;
        else if (!(&stage_len))
            stage_len <= stage_len + 1'b1;
    end
    a_flag_entry: assert property (s_enter |-> stat_out.timeout_flag)
        else $error("no flag");
    a_count_run: assert property (s_enter |-> $past(ctrl_in.run))
        else $error("no run");
    a_irq_mask: assert property (!ctrl_in.int_enable |=> !stat_out.irq)
        else $error("irq unmasked");
    a_stage_len: assert property (s_fire |->
        stage_len == {1'b0, WDT_RST_CYCLES})
        else $error("stage length");
    a_no_rescue: assert property (s_fire |-> !$past(ctrl_in.restart, 2))
        else $error("fired after restart");
    a_reinit_wdt: assert property (stat_out.sys_reset |=>
        !stat_out.sys_reset && !stat_out.timeout_flag)
        else $error("no reinit");
endmodule : wdt_chk
bind wdt_core wdt_chk u_chk (.core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in), .ctrl_in(ctrl_in), .stat_out(stat_out));

// file: tb/wdt_core_tb.sv
/* wdt_core_tb: drives watchdog controls; assumes selects 00 and 01 */
`timescale 1ns/1ns
module wdt_core_tb;
    import wdt_pkg::*;
    logic core_clk_in = 1'b0, arst_n_in = 1'b0;
    wdt_ctrl_t ctrl = '0;
    wdt_stat_t stat;
    int fail_count = 0, checks_done = 0;
    wdt_core dut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .ctrl_in(ctrl), .stat_out(stat));
    // 50 MHz system clock
    initial forever #10 core_clk_in = ~core_clk_in;
    task automatic cmp(input logic got, input logic exp);
        checks_done++;
        fail_count += (got !== exp);
        if (got !== exp)
            $display("wrong value %0t %0h %0h", $time, got, exp);
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        @(negedge core_clk_in);
    endtask : tick
    task automatic kick(input logic en, input logic [1:0] sel);
        @(posedge core_clk_in);
        ctrl <= '{1'b1, 1'b1, en, 1'b0, sel};
        @(posedge core_clk_in);
        ctrl.restart <= 1'b0;
    endtask : kick
    // nobody restarts: flag, irq, then system reset 512 clocks on
    task automatic run_out;
        kick(1'b1, 2'h0);
        tick(32'h7FFF);
        cmp(stat.timeout_flag, 1'b0);
        tick(1);
        cmp(stat.timeout_flag, 1'b1);
        cmp(stat.reset_stage, 1'b1);
        tick(1);
        cmp(stat.irq, 1'b1);
        tick(510);
        cmp(stat.sys_reset, 1'b0);
        tick(1);
        cmp(stat.sys_reset, 1'b1);
        cmp(stat.reset_stage, 1'b0);
        tick(1);
        cmp(stat.sys_reset, 1'b0);
        cmp(stat.timeout_flag, 1'b0);
    endtask : run_out
    // select 01 outlasts 2^15; then a restart in the stage averts reset
    task automatic rescue;
        kick(1'b0, 2'h1);
        tick(32'h8001);
        cmp(stat.timeout_flag, 1'b0);
        @(posedge core_clk_in);
        ctrl.timeout_select <= 2'h0;
        tick(32'h7FFD);
        cmp(stat.timeout_flag, 1'b0);
        tick(1);
        cmp(stat.timeout_flag, 1'b1);
        cmp(stat.irq, 1'b0);
        kick(1'b0, 2'h0);
        tick(520);
        cmp(stat.reset_stage, 1'b0);
        cmp(stat.timeout_flag, 1'b1);
    endtask : rescue
    // flag_clear drops the flag that a restart alone left set
    task automatic clear_flag;
        @(posedge core_clk_in);
        ctrl.flag_clear <= 1'b1;
        @(posedge core_clk_in);
        ctrl.flag_clear <= 1'b0;
        tick(0);
        cmp(stat.timeout_flag, 1'b0);
    endtask : clear_flag
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    // reset for two clocks, then the scenarios
    initial
    begin
        repeat (2) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        run_out();
        rescue();
        clear_flag();
        close_out();
    end
endmodule : wdt_core_tb
